// File: verilog/pwmg_top.v
// How it works
// - Request word holds change-request bits at 0, 4, 8, 12.
// - Readback request bits sit one above each change-request bit.
// - Completion word mirrors the request word bit for bit.
// - Change request loads the staged frequency and on-ratio as active.
// - Change-completion bit rises once the new values are applied.
// - Completion clears only after the request bit is seen low.
// - A request updates all of a group's parameters together.
// - A rejected setting shows code 842 and raises an alarm bit.
// - An invalid value leaves the previous active parameters running.
// - Frequency alarm bit is 1 below 10 Hz or above 2.5 kHz, else 0.
// - On-ratio alarm bit is 1 outside the effective range, else 0.
// - Run bit 0 of each control field starts and stops output.
// - Status field bit 0 is 1 while output runs.
// - Terminal word bits 0, 4, 8, 12 show a producing terminal.
// - Each group outputs a rectangle at its frequency and on-ratio.
// - Accepted frequencies are 10 Hz to 2.5 kHz inclusive.
// - On-ratio lies within delay times frequency of 0 and 100.
//
// Our own choices: the address map and the strobed register port.
`include "pwmg_map.vh"

module pwmg_top (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Register port
    input wire [4:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [15:0] bus_rdata,
    // PWM terminals
    output wire [3:0] pwm_out
);
    reg [15:0] req_reg;
    reg [15:0] run_ctrl_reg;
    reg [15:0] run_state_reg;
    reg [15:0] io_err_reg;
    reg [7:0] delay_reg;
    reg [15:0] rdata_next;

    // Next values of the shared words.
    reg [15:0] req_next;
    reg [15:0] run_ctrl_next;
    reg [15:0] io_err_next;
    reg [7:0] delay_next;

    wire [15:0] done_word;
    wire [15:0] term_word;
    wire [7:0] alarm_word;
    wire [63:0] stage_freq_flat;
    wire [63:0] stage_duty_flat;
    wire [63:0] rb_freq_flat;
    wire [63:0] rb_duty_flat;
    wire [3:0] chan_active;
    wire wr_req;
    wire wr_run;
    wire wr_delay;
    wire [5:0] rd_lsb;

    assign wr_req = bus_wr && (bus_addr == `PWMG_REG_REQ);
    assign wr_run = bus_wr && (bus_addr == `PWMG_REG_RUN_CTRL);
    assign wr_delay = bus_wr && (bus_addr == `PWMG_REG_DELAY);
    assign rd_lsb = {bus_addr[1:0], 4'h0};

    // Shared control words; masked bits are dropped on the way in, so they read as zero.
    always @*
    begin
        req_next = req_reg;
        run_ctrl_next = run_ctrl_reg;
        delay_next = delay_reg;
        io_err_next = `PWMG_RST_WORD;
        if (wr_req)
            req_next = bus_wdata & `PWMG_REQ_MASK;
        if (wr_run)
            run_ctrl_next = bus_wdata & `PWMG_RUN_MASK;
        if (wr_delay)
            delay_next = bus_wdata[7:0];
        // The error code stands while any group still holds an alarm.
        if (alarm_word != 8'h00)
            io_err_next = `PWMG_ERR_CODE;
    end

    // The run state follows the control word one edge later, as the channels do.
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_reg <= `PWMG_RST_WORD;
            run_ctrl_reg <= `PWMG_RST_WORD;
            run_state_reg <= `PWMG_RST_WORD;
            io_err_reg <= `PWMG_RST_WORD;
            delay_reg <= `PWMG_RST_DELAY;
        end
        else if (clk_en)
        begin
            req_reg <= req_next;
            run_ctrl_reg <= run_ctrl_next;
            delay_reg <= delay_next;
            io_err_reg <= io_err_next;
            run_state_reg <= run_ctrl_reg;
        end
    end

    // Per-group staging, handshake and output.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_grp
            // Staged values as software wrote them.
            reg [15:0] stage_freq_reg;
            reg [15:0] stage_duty_reg;
            reg [15:0] stage_freq_next;
            reg [15:0] stage_duty_next;
            // Values in use by the channel and their readback copies.
            reg [11:0] act_freq_reg;
            reg [6:0] act_duty_reg;
            reg [11:0] rb_freq_reg;
            reg [6:0] rb_duty_reg;
            reg [11:0] act_freq_next;
            reg [6:0] act_duty_next;
            reg [11:0] rb_freq_next;
            reg [6:0] rb_duty_next;
            // Handshake and alarm flags.
            reg chg_done_reg;
            reg rb_done_reg;
            reg freq_alarm_reg;
            reg duty_alarm_reg;
            reg chg_done_next;
            reg rb_done_next;
            reg freq_alarm_next;
            reg duty_alarm_next;

            localparam integer grp_num = gi;
            wire chg_req;
            wire rb_req;
            wire chg_take;
            wire rb_take;
            wire freq_bad;
            wire duty_bad;
            wire wr_freq;
            wire wr_duty;

            assign chg_req = req_reg[4 * gi + `PWMG_BIT_CHG];
            assign rb_req = req_reg[4 * gi + `PWMG_BIT_RB];
            // A request is taken once; the done bit masks it until software drops it.
            assign chg_take = chg_req && !chg_done_reg;
            assign rb_take = rb_req && !rb_done_reg;
            assign wr_freq = bus_wr && (bus_addr == {`PWMG_BASE_FREQ, grp_num[1:0]});
            assign wr_duty = bus_wr && (bus_addr == {`PWMG_BASE_DUTY, grp_num[1:0]});

            // Alarms come from the staged pair, before it is taken over.
            pwmg_check u_check (
                .freq(stage_freq_reg),
                .duty(stage_duty_reg),
                .delay_us(delay_reg),
                .freq_alarm(freq_bad),
                .duty_alarm(duty_bad)
            );

            // Next values of the group; a change request is judged once per handshake.
            always @*
            begin
                stage_freq_next = stage_freq_reg;
                stage_duty_next = stage_duty_reg;
                act_freq_next = act_freq_reg;
                act_duty_next = act_duty_reg;
                rb_freq_next = rb_freq_reg;
                rb_duty_next = rb_duty_reg;
                chg_done_next = chg_done_reg;
                rb_done_next = rb_done_reg;
                freq_alarm_next = freq_alarm_reg;
                duty_alarm_next = duty_alarm_reg;
                if (wr_freq)
                    stage_freq_next = bus_wdata;
                if (wr_duty)
                    stage_duty_next = bus_wdata;
                if (chg_take)
                begin
                    freq_alarm_next = freq_bad;
                    duty_alarm_next = duty_bad;
                    // An accepted pair fits the active widths, so the cut loses nothing.
                    if (!freq_bad && !duty_bad)
                    begin
                        act_freq_next = stage_freq_reg[11:0];
                        act_duty_next = stage_duty_reg[6:0];
                    end
                    // A rejected pair leaves the active values untouched.
                    chg_done_next = 1'b1;
                end
                else if (!chg_req && chg_done_reg)
                    chg_done_next = 1'b0;
                if (rb_take)
                begin
                    rb_freq_next = act_freq_reg;
                    rb_duty_next = act_duty_reg;
                    rb_done_next = 1'b1;
                end
                else if (!rb_req && rb_done_reg)
                    rb_done_next = 1'b0;
            end

            always @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    stage_freq_reg <= {4'h0, `PWMG_RST_FREQ};
                    stage_duty_reg <= {9'h000, `PWMG_RST_DUTY};
                    act_freq_reg <= `PWMG_RST_FREQ;
                    act_duty_reg <= `PWMG_RST_DUTY;
                    rb_freq_reg <= `PWMG_RST_FREQ;
                    rb_duty_reg <= `PWMG_RST_DUTY;
                    chg_done_reg <= 1'b0;
                    rb_done_reg <= 1'b0;
                    freq_alarm_reg <= 1'b0;
                    duty_alarm_reg <= 1'b0;
                end
                else if (clk_en)
                begin
                    stage_freq_reg <= stage_freq_next;
                    stage_duty_reg <= stage_duty_next;
                    act_freq_reg <= act_freq_next;
                    act_duty_reg <= act_duty_next;
                    rb_freq_reg <= rb_freq_next;
                    rb_duty_reg <= rb_duty_next;
                    chg_done_reg <= chg_done_next;
                    rb_done_reg <= rb_done_next;
                    freq_alarm_reg <= freq_alarm_next;
                    duty_alarm_reg <= duty_alarm_next;
                end
            end

            // The channel sees only the active values, so staging never disturbs output.
            pwmg_chan u_chan (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .clk_en(clk_en),
                .run(run_ctrl_reg[4 * gi + `PWMG_BIT_RUN]),
                .freq(act_freq_reg),
                .duty(act_duty_reg),
                .pwm_out(pwm_out[gi]),
                .active(chan_active[gi])
            );

            // Word assembly; unused field bits read as zero.
            assign done_word[4 * gi + `PWMG_BIT_CHG] = chg_done_reg;
            assign done_word[4 * gi + `PWMG_BIT_RB] = rb_done_reg;
            assign done_word[4 * gi + 3:4 * gi + 2] = 2'b00;
            assign term_word[4 * gi] = chan_active[gi];
            assign term_word[4 * gi + 3:4 * gi + 1] = 3'h0;
            assign alarm_word[2 * gi] = freq_alarm_reg;
            assign alarm_word[2 * gi + 1] = duty_alarm_reg;
            assign stage_freq_flat[16 * gi + 15:16 * gi] = stage_freq_reg;
            assign stage_duty_flat[16 * gi + 15:16 * gi] = stage_duty_reg;
            assign rb_freq_flat[16 * gi + 15:16 * gi] = {4'h0, rb_freq_reg};
            assign rb_duty_flat[16 * gi + 15:16 * gi] = {9'h000, rb_duty_reg};
        end
    endgenerate

    // Read multiplexer; unmapped words read as zero.
    always @*
    begin
        rdata_next = 16'h0000;
        case (bus_addr)
            `PWMG_REG_REQ: rdata_next = req_reg;
            `PWMG_REG_DONE: rdata_next = done_word;
            `PWMG_REG_ALARM: rdata_next = {8'h00, alarm_word};
            `PWMG_REG_TERM: rdata_next = term_word;
            `PWMG_REG_RUN_CTRL: rdata_next = run_ctrl_reg;
            `PWMG_REG_RUN_STATE: rdata_next = run_state_reg;
            `PWMG_REG_IO_ERR: rdata_next = io_err_reg;
            `PWMG_REG_DELAY: rdata_next = {8'h00, delay_reg};
            default:
            begin
                case (bus_addr[4:2])
                    `PWMG_BASE_FREQ: rdata_next = stage_freq_flat[rd_lsb +: 16];
                    `PWMG_BASE_DUTY: rdata_next = stage_duty_flat[rd_lsb +: 16];
                    `PWMG_BASE_RB_FREQ: rdata_next = rb_freq_flat[rd_lsb +: 16];
                    `PWMG_BASE_RB_DUTY: rdata_next = rb_duty_flat[rd_lsb +: 16];
                    default: rdata_next = 16'h0000;
                endcase
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            bus_rdata <= 16'h0000;
        else if (clk_en)
        begin
            if (bus_rd)
                bus_rdata <= rdata_next;
            else
                bus_rdata <= 16'h0000;
        end
    end
endmodule

// File: verilog/pwmg_map.vh
`ifndef PWMG_MAP_VH
`define PWMG_MAP_VH

// Register word indexes on the plain register port.
`define PWMG_REG_REQ 5'h00
`define PWMG_REG_DONE 5'h01
`define PWMG_REG_ALARM 5'h02
`define PWMG_REG_TERM 5'h03
`define PWMG_REG_RUN_CTRL 5'h04
`define PWMG_REG_RUN_STATE 5'h05
`define PWMG_REG_IO_ERR 5'h06
`define PWMG_REG_DELAY 5'h07
`define PWMG_BASE_FREQ 3'h2
`define PWMG_BASE_DUTY 3'h3
`define PWMG_BASE_RB_FREQ 3'h4
`define PWMG_BASE_RB_DUTY 3'h5

// Field positions within each four-bit group field.
`define PWMG_BIT_CHG 0
`define PWMG_BIT_RB 1
`define PWMG_BIT_RUN 0
`define PWMG_REQ_MASK 16'h3333
`define PWMG_RUN_MASK 16'h1111

// Reset values.
`define PWMG_RST_FREQ 12'h00a
`define PWMG_RST_DUTY 7'h00
`define PWMG_RST_DELAY 8'h28
`define PWMG_RST_WORD 16'h0000

// Limits, error code and timing.
`define PWMG_FREQ_MIN 16'h000a
`define PWMG_FREQ_MAX 16'h09c4
`define PWMG_DUTY_MAX 16'h0064
`define PWMG_DUTY_FULL 7'h64
`define PWMG_DELAY_SCALE 14'h2710
`define PWMG_ERR_CODE 16'h034a
`define PWMG_CLK_HZ 27'h2faf080
`define PWMG_DUTY_STEP 19'h7a120

`endif

// File: verilog/pwmg_check.v
`include "pwmg_map.vh"

// Judges a staged frequency and on-ratio pair against the accepted ranges.
module pwmg_check (
    // Staged values
    input wire [15:0] freq,
    input wire [15:0] duty,
    input wire [7:0] delay_us,
    // Verdict
    output wire freq_alarm,
    output wire duty_alarm
);
    wire [23:0] edge_prod;
    wire [29:0] low_scaled;
    wire [6:0] duty_rest;
    wire [20:0] high_scaled;

    // The on-ratio window shrinks by delay times frequency at each end, in percent.
    assign edge_prod = delay_us * freq;
    assign low_scaled = duty * `PWMG_DELAY_SCALE;
    assign duty_rest = `PWMG_DUTY_FULL - duty[6:0];
    assign high_scaled = duty_rest * `PWMG_DELAY_SCALE;

    assign freq_alarm = (freq > `PWMG_FREQ_MAX) || (freq < `PWMG_FREQ_MIN);
    assign duty_alarm = (duty > `PWMG_DUTY_MAX)
        || (low_scaled < {6'h00, edge_prod})
        || ({3'h0, high_scaled} < edge_prod);
endmodule

// File: verilog/pwmg_chan.v
`include "pwmg_map.vh"

// One PWM output built on a phase accumulator that wraps at the clock rate.
module pwmg_chan (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Active settings
    input wire run,
    input wire [11:0] freq,
    input wire [6:0] duty,
    // Output
    output reg pwm_out,
    output reg active
);
    reg [26:0] phase_reg;
    reg [26:0] phase_next;
    wire [26:0] phase_sum;
    wire [26:0] high_limit;

    // Adding the frequency each cycle wraps the phase exactly freq times a second.
    assign phase_sum = phase_reg + {15'h0000, freq};
    assign high_limit = duty * `PWMG_DUTY_STEP;

    always @*
    begin
        if (!run)
            phase_next = 27'h0000000;
        else if (phase_sum >= `PWMG_CLK_HZ)
            phase_next = phase_sum - `PWMG_CLK_HZ;
        else
            phase_next = phase_sum;
    end

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_reg <= 27'h0000000;
            pwm_out <= 1'b0;
            active <= 1'b0;
        end
        else if (clk_en)
        begin
            phase_reg <= phase_next;
            pwm_out <= run && (phase_reg < high_limit);
            active <= run && (duty != 7'h00);
        end
    end
endmodule

// File: dv/pwmg_top_chk.sv
`include "pwmg_map.vh"

module pwmg_top_chk (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    // Register port
    input wire [4:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [15:0] bus_rdata,
    // PWM terminals
    input wire [3:0] pwm_out
);
    reg [15:0] req_reg;
    reg [15:0] run_reg;
    reg [4:0] ra_reg;
    reg rv_reg;
    wire [3:0] run_g = {run_reg[12], run_reg[8], run_reg[4], run_reg[0]};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // Shadows of the request and run control words and of the last read, frozen with clk_en.
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_reg <= 16'h0000;
            run_reg <= 16'h0000;
            ra_reg <= 5'h00;
            rv_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            rv_reg <= bus_rd;
            ra_reg <= bus_addr;
            if (bus_wr && bus_addr == `PWMG_REG_REQ)
                req_reg <= bus_wdata & `PWMG_REQ_MASK;
            if (bus_wr && bus_addr == `PWMG_REG_RUN_CTRL)
                run_reg <= bus_wdata & `PWMG_RUN_MASK;
        end
    end
    rdata_idle_a: assert property (!rv_reg |-> bus_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    unmapped_zero_a: assert property (rv_reg && ra_reg > 5'h17 |-> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");
    req_word_a: assert property (
        rv_reg && ra_reg == `PWMG_REG_REQ |-> bus_rdata == req_reg)
        else $error("request word readback wrong");
    run_word_a: assert property (
        rv_reg && ra_reg == `PWMG_REG_RUN_CTRL |-> bus_rdata == run_reg)
        else $error("run control readback wrong");
    done_mirror_a: assert property (rv_reg && ra_reg == `PWMG_REG_DONE |->
        (bus_rdata & ~(req_reg | $past(req_reg) | $past(req_reg, 2))) == 16'h0000)
        else $error("completion bit without request");
    err_code_a: assert property (rv_reg && ra_reg == `PWMG_REG_IO_ERR |->
        bus_rdata == 16'h0000 || bus_rdata == `PWMG_ERR_CODE)
        else $error("bad error code");
    alarm_bits_a: assert property (
        rv_reg && ra_reg == `PWMG_REG_ALARM |-> bus_rdata[15:8] == 8'h00)
        else $error("alarm unused bits set");
    state_bits_a: assert property (rv_reg && ra_reg inside {5'h03, 5'h05} |->
        (bus_rdata & ~(run_reg | $past(run_reg) | $past(run_reg, 2) | $past(run_reg, 3))) == 0)
        else $error("status bit without run");
    stopped_low_a: assert property (
        clk_en |-> (pwm_out & ~(run_g | $past(run_g) | $past(run_g, 2))) == 4'h0)
        else $error("stopped output not low");
    cover property (rv_reg && ra_reg == `PWMG_REG_DONE && bus_rdata != 16'h0000);
    cover property (rv_reg && ra_reg == `PWMG_REG_IO_ERR && bus_rdata == `PWMG_ERR_CODE);
    cover property ($rose(pwm_out[0]));
endmodule

bind pwmg_top pwmg_top_chk chk (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pwm_out(pwm_out));

// File: dv/pwmg_top_test.sv
`include "pwmg_map.vh"

module pwmg_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg sys_clk = 0;
    reg arst_n = 0;
    reg clk_en = 1;
    reg [4:0] bus_addr = 0;
    reg [15:0] bus_wdata = 0;
    reg bus_wr = 0;
    reg bus_rd = 0;
    reg rv = 0;
    wire [15:0] bus_rdata;
    wire [3:0] pwm_out;
    integer fail_count = 0, n_tests = 0, seed = 76001, cyc = 0, i, f, d, lo, h, l;
    integer af[4] = '{10, 10, 10, 10};
    integer ad[4] = '{0, 0, 0, 0};
    integer tf[6] = '{2501, 9, 2000, 2000, 2000, 2500};
    integer td[6] = '{50, 50, 7, 93, 8, 25};
    integer ta[6] = '{1, 1, 2, 2, 0, 0};
    logic [15:0] exp_q[$];
    string nm_q[$];
    always #10 sys_clk = ~sys_clk;
    pwmg_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pwm_out(pwm_out));
    task print_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task automatic check(string nm, logic [15:0] e, logic [15:0] g);
    begin
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // One bus cycle; every signal is assigned once per edge, so cycles chain freely.
    task op(input w, input r, input [4:0] a, input [15:0] dt);
    begin
        bus_wr <= w;
        bus_rd <= r;
        bus_addr <= a;
        bus_wdata <= dt;
        @(posedge sys_clk);
    end
    endtask
    task rd(input [4:0] a, input [15:0] e, input string nm);
    begin
        exp_q.push_back(e);
        nm_q.push_back(nm);
        op(0, 1, a, 16'h0000);
    end
    endtask
    always @(posedge sys_clk)
        if (clk_en)
            rv <= bus_rd;
    always @(negedge sys_clk)
        if (rv && exp_q.size() > 0)
            check(nm_q.pop_front(), exp_q.pop_front(), bus_rdata);
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fail_count++;
            $display("Error timeout expected %h seen %h", 16'h0000, 16'h0001);
            print_verdict;
        end
    end
    // Change then readback handshake for group g; al is the expected two-bit alarm.
    task hs(input integer g, input integer fq, input integer dq, input integer al);
    begin
        op(1, 0, 5'h08 + g, fq);
        op(1, 0, 5'h0c + g, dq);
        op(1, 0, `PWMG_REG_REQ, 16'h0001 << 4 * g);
        op(0, 0, 5'h00, 16'h0000);
        rd(`PWMG_REG_DONE, 16'h0001 << 4 * g, "done");
        rd(`PWMG_REG_ALARM, al << 2 * g, "alarm");
        rd(`PWMG_REG_IO_ERR, al != 0 ? `PWMG_ERR_CODE : 16'h0000, "io error");
        rd(`PWMG_REG_DONE, 16'h0001 << 4 * g, "done held");
        op(1, 0, `PWMG_REG_REQ, 16'h0000);
        op(0, 0, 5'h00, 16'h0000);
        rd(`PWMG_REG_DONE, 16'h0000, "done cleared");
        if (al == 0)
        begin
            af[g] = fq;
            ad[g] = dq;
        end
        op(1, 0, `PWMG_REG_REQ, 16'h0002 << 4 * g);
        op(0, 0, 5'h00, 16'h0000);
        rd(`PWMG_REG_DONE, 16'h0002 << 4 * g, "readback done");
        rd(5'h10 + g, af[g], "active freq");
        rd(5'h14 + g, ad[g], "active duty");
        op(1, 0, `PWMG_REG_REQ, 16'h0000);
        op(0, 0, 5'h00, 16'h0000);
        rd(`PWMG_REG_DONE, 16'h0000, "readback cleared");
    end
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1;
        @(posedge sys_clk);
        for (i = 0; i < 17; i++)
            rd(i == 16 ? 24 : i, i == 7 ? 16'h0028 : (i > 7 && i < 12 ? 16'h000a : 0), "reset");
        op(1, 0, `PWMG_REG_DELAY, 16'hffff);
        rd(`PWMG_REG_DELAY, 16'h00ff, "delay mask");
        op(1, 0, `PWMG_REG_DONE, 16'hffff);
        rd(`PWMG_REG_DONE, 16'h0000, "done read only");
        op(1, 0, `PWMG_REG_REQ, 16'hcccc);
        rd(`PWMG_REG_REQ, 16'h0000, "request unused");
        op(1, 0, `PWMG_REG_DELAY, 16'h0028);
        clk_en <= 0;
        op(1, 0, `PWMG_REG_RUN_CTRL, 16'h1111);
        clk_en <= 1;
        rd(`PWMG_REG_RUN_CTRL, 16'h0000, "frozen write");
        $display("register test done");
        for (i = 0; i < 4; i++)
        begin
            f = 10 + {$random(seed)} % 2491;
            lo = (40 * f + 9999) / 10000;
            d = lo + {$random(seed)} % (101 - 2 * lo);
            hs(i, f, d, 0);
        end
        for (i = 0; i < 6; i++)
            hs(0, tf[i], td[i], ta[i]);
        $display("handshake test done");
        op(1, 0, `PWMG_REG_RUN_CTRL, 16'h1111);
        op(0, 0, 5'h00, 16'h0000);
        op(0, 0, 5'h00, 16'h0000);
        rd(`PWMG_REG_RUN_STATE, 16'h1111, "run state");
        rd(`PWMG_REG_TERM, 16'h1111, "terminal");
        op(0, 0, 5'h00, 16'h0000);
        h = 0;
        l = 0;
        // Skip the period already under way so that a whole high phase is counted.
        for (i = 0; i < 30000 && pwm_out[0]; i++)
            @(negedge sys_clk);
        for (i = 0; i < 30000 && !pwm_out[0]; i++)
            @(negedge sys_clk);
        while (pwm_out[0] && h < 30000)
        begin
            @(negedge sys_clk);
            h++;
        end
        while (!pwm_out[0] && l < 30000)
        begin
            @(negedge sys_clk);
            l++;
        end
        check("pwm high", 16'd5000, h[15:0]);
        check("pwm low", 16'd15000, l[15:0]);
        @(posedge sys_clk);
        op(1, 0, `PWMG_REG_RUN_CTRL, 16'h0000);
        op(0, 0, 5'h00, 16'h0000);
        @(negedge sys_clk);
        check("pwm stopped", 16'h0000, {12'h000, pwm_out});
        @(posedge sys_clk);
        rd(`PWMG_REG_RUN_STATE, 16'h0000, "run stopped");
        rd(`PWMG_REG_TERM, 16'h0000, "terminal idle");
        op(0, 0, 5'h00, 16'h0000);
        op(0, 0, 5'h00, 16'h0000);
        $display("run test done");
        print_verdict;
    end
endmodule
